/* logic/reset_ctrl_pkg.sv */
// Package: constants, timing counts and carrier types for the reset source and start-up delay block.
// Summary of operation
// - Pin low longer than 500 ns resets, even with no clock; driver holds it longer; here the pin filter counts core_clk, so no clock means no reset.
// - During reset all I/O registers take initial values; fetch then starts at address 000.
// - No reset source ever touches the general-purpose register file.
// - Watchdog reset happens only when watchdog enabled and its period expired.
// - Watchdog time-out gives one-clock reset pulse; delay starts on its falling edge.
// - After reset pin returns high, delay timer runs, core released after time-out.
// - Power-on threshold reached starts delay counter; core held until its time-out.
// - Supply falling below power-on level reasserts reset immediately, without delay.
// - Two-bit select: 00/01 long 64K, 10 gives 4K, 11 short count, all plus 18 clocks.
// - Oscillator cycles: code 11 gives 8 or 32 by brown-out enable, 4K, 64K.
// - Wake from power-down uses only the 18-clock part, skipping oscillator count.
// - Delay select fuses default to 00, the longest start-up delay.
// - Brown-out monitor active only when enable fuse programmed; programmed reads 0.
// - Brown-out asserts reset at once; release after same selectable delay as power-on.
// - Level fuse programmed selects 4.0V trigger, unprogrammed selects 2.7V.
// - Brown-out recognised only after low lasts about 3 us at 4.0V, 7 us at 2.7V.
// - Cause register bits 7 to 4 always read as zero.
// - Bit 3 set by watchdog reset; cleared by power-on reset or software zero write.
// - Bit 2 set by brown-out reset; cleared by power-on reset or software zero write.
// - Bit 1 set by pin reset; cleared by power-on reset or software zero write.
// - Bit 0 set by power-on reset; cleared only by software writing zero or by the rst input.
package reset_ctrl_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int PIN_MIN_LOW_NS = 500;
  localparam int PIN_FILTER_CYCLES = (PIN_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOD_HI_FILTER_NS = 3000;
  localparam int BOD_LO_FILTER_NS = 7000;
  localparam int BOD_HI_FILTER_CYCLES = (BOD_HI_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOD_LO_FILTER_CYCLES = (BOD_LO_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLOCK_PART_CYCLES = 18;
  localparam int OSC_SHORT_NOBOD = 8;
  localparam int OSC_SHORT_BOD = 32;
  localparam int OSC_MEDIUM = 4096;
  localparam int OSC_LONG = 65536;

  localparam logic [1:0] SEL_LONG_A = 2'h0;
  localparam logic [1:0] SEL_LONG_B = 2'h1;
  localparam logic [1:0] SEL_MEDIUM = 2'h2;
  localparam logic [1:0] SEL_SHORT = 2'h3;
  localparam logic [1:0] SEL_RESET_VALUE = 2'h0;
  localparam logic FUSE_PROGRAMMED = 1'h0;

  localparam int CAUSE_WIDTH = 8;
  localparam int POWERUP_BIT = 0;
  localparam int PIN_BIT = 1;
  localparam int BROWNOUT_BIT = 2;
  localparam int WATCHDOG_BIT = 3;
  localparam logic [7:0] CAUSE_USED_MASK = 8'h0F;
  localparam logic [7:0] CAUSE_RESET_VALUE = 8'h00;

  localparam logic [8:0] RESET_FETCH_ADDR = 9'h000;

  typedef struct packed {
    logic [1:0] startup_delay_select_fuse;
    logic supply_monitor_enable_fuse;
    logic supply_trigger_level_fuse;
  } fuse_set_t;

  typedef struct packed {
    logic por_low;
    logic pin_low;
    logic brownout;
    logic watchdog;
  } source_set_t;

endpackage

/* logic/low_level_filter.sv */
// Glitch filter: reports a level only after it has lasted a given number of clocks.
module low_level_filter
  import reset_ctrl_pkg::*;
#(
  parameter int COUNT_WIDTH = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Sampled level and required length
  input wire logic level_in,
  input wire logic [COUNT_WIDTH-1:0] need_cycles,
  // Qualified level
  output logic level_out
);

  typedef struct packed {
    logic [COUNT_WIDTH-1:0] count;
    logic out;
  } filt_state_t;

  filt_state_t s_q;
  filt_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (!level_in)
    begin
      s_d.count = '0;
      s_d.out = 1'b0;
    end
    else if (s_q.count >= need_cycles)
    begin
      s_d.out = 1'b1;
    end
    else
    begin
      s_d.count = s_q.count + COUNT_WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign level_out = s_q.out;

endmodule

/* logic/edge_counter.sv */
// Counts rising edges of a slow synchronised oscillator up to a target and flags completion.
module edge_counter
  import reset_ctrl_pkg::*;
#(
  parameter int COUNT_WIDTH = 17
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic osc_sync,
  input wire logic [COUNT_WIDTH-1:0] target,
  // Status
  output logic done
);

  typedef struct packed {
    logic [COUNT_WIDTH-1:0] count;
    logic last_osc;
    logic done;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.last_osc = osc_sync;
    if (clear)
    begin
      s_d.count = '0;
      s_d.done = 1'b0;
    end
    else if (s_q.count >= target)
    begin
      s_d.done = 1'b1;
    end
    else if (osc_sync && !s_q.last_osc)
    begin
      s_d.count = s_q.count + COUNT_WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign done = s_q.done;

endmodule

/* logic/reset_source_and_startup_delay.sv */
// Reset controller: source combining, start-up delay and reset-cause flags.
module reset_source_and_startup_delay
  import reset_ctrl_pkg::*;
#(
  parameter int LONG_OSC_CYCLES = OSC_LONG,
  parameter int MEDIUM_OSC_CYCLES = OSC_MEDIUM
)
(
  // Clock and synchronous reset
  input wire logic core_clk,
  input wire logic rst,
  // Supply monitors and pin, asynchronous to core_clk
  input wire logic supply_below_por,
  input wire logic supply_drop_detector,
  input wire logic reset_pin_n,
  input wire logic watchdog_osc,
  // Watchdog, same clock domain
  input wire logic watchdog_enable,
  input wire logic watchdog_expired,
  // Fuses, static
  input wire logic [1:0] startup_delay_select_fuse,
  input wire logic supply_monitor_enable_fuse,
  input wire logic supply_trigger_level_fuse,
  // Power-down wake request
  input wire logic wake_from_powerdown,
  // Cause register access
  input wire logic cause_write,
  input wire logic [7:0] cause_wdata,
  output logic [7:0] reset_cause_flags,
  // Reset outputs to core and I/O
  output logic core_reset,
  output logic io_reset,
  output logic [8:0] fetch_addr,
  output logic brownout_monitor_active,
  output logic [1:0] effective_delay_select
);

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_OSC_WAIT,
    ST_CLK_WAIT,
    ST_RUN,
    ST_SLEEP
  } phase_t;

  typedef struct packed {
    logic [1:0] por_sync;
    logic [1:0] pin_sync;
    logic [1:0] bod_sync;
    logic [1:0] osc_sync;
    phase_t phase;
    logic [4:0] clk_count;
    logic wdt_pulse;
    logic [7:0] cause;
    logic core_reset;
    logic io_reset;
    logic [8:0] fetch_addr;
    logic bod_active;
    logic [1:0] sel;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic pin_low_q;
  logic bod_low_q;
  logic osc_done;
  logic osc_clear;
  logic [7:0] bod_need;
  logic [16:0] osc_target;
  logic bod_enabled;
  source_set_t src;
  logic any_source;

  // Compare against the chosen hold time; counts start from zero, so the need is one less.
  function automatic logic [7:0] filter_need(input int cycles);
    filter_need = 8'(cycles - 1);
  endfunction

  // Oscillator cycles for the real-time part of the delay.
  function automatic logic [16:0] osc_cycles(input logic [1:0] sel, input logic bod_on);
    case (sel)
      SEL_SHORT: osc_cycles = bod_on ? 17'(OSC_SHORT_BOD) : 17'(OSC_SHORT_NOBOD);
      SEL_MEDIUM: osc_cycles = 17'(MEDIUM_OSC_CYCLES);
      default: osc_cycles = 17'(LONG_OSC_CYCLES);
    endcase
  endfunction

  assign bod_enabled = (supply_monitor_enable_fuse == FUSE_PROGRAMMED);
  // The programmed level fuse selects the higher trigger and its shorter filter.
  assign bod_need = (supply_trigger_level_fuse == FUSE_PROGRAMMED)
    ? filter_need(BOD_HI_FILTER_CYCLES) : filter_need(BOD_LO_FILTER_CYCLES);
  assign osc_target = osc_cycles(startup_delay_select_fuse, bod_enabled);

  // A pin pulse only counts when longer than the minimum low time.
  low_level_filter #(
    .COUNT_WIDTH(8)
  ) pin_filter (
    .core_clk(core_clk),
    .rst(rst),
    .level_in(s_q.pin_sync[1]),
    .need_cycles(filter_need(PIN_FILTER_CYCLES)),
    .level_out(pin_low_q)
  );

  low_level_filter #(
    .COUNT_WIDTH(8)
  ) bod_filter (
    .core_clk(core_clk),
    .rst(rst),
    .level_in(s_q.bod_sync[1] && bod_enabled),
    .need_cycles(bod_need),
    .level_out(bod_low_q)
  );

  edge_counter #(
    .COUNT_WIDTH(17)
  ) osc_counter (
    .core_clk(core_clk),
    .rst(rst),
    .clear(osc_clear),
    .osc_sync(s_q.osc_sync[1]),
    .target(osc_target),
    .done(osc_done)
  );

  always_comb
  begin
    src.por_low = s_q.por_sync[1];
    src.pin_low = pin_low_q;
    src.brownout = bod_low_q;
    src.watchdog = s_q.wdt_pulse;
    any_source = src.por_low || src.pin_low || src.brownout || src.watchdog;
  end

  // The oscillator count only runs in its own phase; anywhere else it is held at zero.
  assign osc_clear = (s_q.phase != ST_OSC_WAIT) || any_source;

  always_comb
  begin
    s_d = s_q;
    s_d.por_sync = {s_q.por_sync[0], supply_below_por};
    s_d.pin_sync = {s_q.pin_sync[0], ~reset_pin_n};
    s_d.bod_sync = {s_q.bod_sync[0], supply_drop_detector};
    s_d.osc_sync = {s_q.osc_sync[0], watchdog_osc};
    s_d.bod_active = bod_enabled;
    s_d.sel = startup_delay_select_fuse;
    s_d.fetch_addr = RESET_FETCH_ADDR;
    // Watchdog pulse lasts exactly one clock, only while the watchdog is on.
    s_d.wdt_pulse = watchdog_enable && watchdog_expired && !s_q.wdt_pulse
      && (s_q.phase == ST_RUN || s_q.phase == ST_SLEEP);

    // Software clears by writing zero; a cause arriving in the same cycle still wins.
    if (cause_write)
    begin
      s_d.cause = s_q.cause & cause_wdata & CAUSE_USED_MASK;
    end
    if (src.por_low)
    begin
      s_d.cause[WATCHDOG_BIT] = 1'b0;
      s_d.cause[BROWNOUT_BIT] = 1'b0;
      s_d.cause[PIN_BIT] = 1'b0;
      s_d.cause[POWERUP_BIT] = 1'b1;
    end
    else
    begin
      if (src.watchdog)
        s_d.cause[WATCHDOG_BIT] = 1'b1;
      if (src.brownout)
        s_d.cause[BROWNOUT_BIT] = 1'b1;
      if (src.pin_low)
        s_d.cause[PIN_BIT] = 1'b1;
    end
    s_d.cause[7:4] = 4'h0;

    case (s_q.phase)
      ST_HOLD:
      begin
        // Leave hold only once every source has gone; the watchdog pulse ending is its falling edge.
        s_d.clk_count = 5'h00;
        if (!any_source)
          s_d.phase = ST_OSC_WAIT;
      end
      ST_OSC_WAIT:
      begin
        if (osc_done)
          s_d.phase = ST_CLK_WAIT;
      end
      ST_CLK_WAIT:
      begin
        if (s_q.clk_count == 5'(CLOCK_PART_CYCLES - 1))
          s_d.phase = ST_RUN;
        else
          s_d.clk_count = s_q.clk_count + 5'h01;
      end
      ST_RUN:
      begin
        if (wake_from_powerdown)
          s_d.phase = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        // Waking skips the oscillator part and only counts system clocks.
        s_d.clk_count = 5'h00;
        if (!wake_from_powerdown)
          s_d.phase = ST_CLK_WAIT;
      end
      default:
      begin
        s_d.phase = ST_HOLD;
      end
    endcase

    // Any source drops the block straight back to hold and restarts the whole delay.
    if (any_source)
    begin
      s_d.phase = ST_HOLD;
    end

    s_d.core_reset = (s_d.phase != ST_RUN) && (s_d.phase != ST_SLEEP);
    // A wake-up count leaves the I/O registers alone, so the clock part only inherits the hold from before it.
    s_d.io_reset = (s_d.phase == ST_HOLD) || (s_d.phase == ST_OSC_WAIT)
      || (s_d.phase == ST_CLK_WAIT && s_q.io_reset);
  end

  // The rst input stands for the block's own power-up, so it clears the cause flags as well.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q.por_sync <= 2'h0;
      s_q.pin_sync <= 2'h0;
      s_q.bod_sync <= 2'h0;
      s_q.osc_sync <= 2'h0;
      s_q.phase <= ST_HOLD;
      s_q.clk_count <= 5'h00;
      s_q.wdt_pulse <= 1'b0;
      s_q.cause <= CAUSE_RESET_VALUE;
      s_q.core_reset <= 1'b1;
      s_q.io_reset <= 1'b1;
      s_q.fetch_addr <= RESET_FETCH_ADDR;
      s_q.bod_active <= 1'b0;
      s_q.sel <= SEL_RESET_VALUE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // The general-purpose register file is not reachable from here and so never cleared.
  assign reset_cause_flags = s_q.cause;
  assign core_reset = s_q.core_reset;
  assign io_reset = s_q.io_reset;
  assign fetch_addr = s_q.fetch_addr;
  assign brownout_monitor_active = s_q.bod_active;
  assign effective_delay_select = s_q.sel;

endmodule

/* verif/reset_ctrl_asserts.sv */
// Checker: port-level assertions for the reset source and start-up delay block.
module reset_ctrl_checker
  import reset_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Sources and controls
  input wire logic supply_below_por,
  input wire logic reset_pin_n,
  input wire logic watchdog_enable,
  input wire logic watchdog_expired,
  input wire logic supply_monitor_enable_fuse,
  input wire logic wake_from_powerdown,
  input wire logic cause_write,
  input wire logic [7:0] cause_wdata,
  // Outputs
  input wire logic [7:0] reset_cause_flags,
  input wire logic core_reset,
  input wire logic [8:0] fetch_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // A counter stands in for a long repetition, which the tools would unroll.
  logic [8:0] pin_cnt_q;
  wire wd_hit = watchdog_enable & watchdog_expired;
  always_ff @(posedge core_clk)
  begin
    if (reset_pin_n)
      pin_cnt_q <= 9'h000;
    else if (pin_cnt_q != 9'h1FF)
      pin_cnt_q <= pin_cnt_q + 9'h001;
  end
  fetch_at_zero_a: assert property (fetch_addr == RESET_FETCH_ADDR)
    else $error("fetch address not zero");
  upper_bits_zero_a: assert property (reset_cause_flags[7:4] == 4'h0)
    else $error("upper cause bits set");
  por_immediate_a: assert property (supply_below_por && !wake_from_powerdown |-> ##[1:5] core_reset)
    else $error("no reset on low supply");
  pin_hold_a: assert property (pin_cnt_q > 9'h014 |-> core_reset)
    else $error("long pin low without reset");
  wdog_reset_a: assert property (wd_hit && !wake_from_powerdown |-> ##[1:3] core_reset)
    else $error("watchdog expiry without reset");
  wdog_flag_cause_a: assert property ($rose(reset_cause_flags[3])
    |-> $past(wd_hit) || $past(wd_hit, 2) || $past(wd_hit, 3))
    else $error("watchdog flag without expiry");
  bod_flag_fuse_a: assert property ($rose(reset_cause_flags[2]) |-> !supply_monitor_enable_fuse)
    else $error("brown-out flag with monitor off");
  por_flag_clear_a: assert property ($fell(reset_cause_flags[0]) |-> $past(cause_write) && !$past(cause_wdata[0]))
    else $error("power-up flag cleared without write");
  release_gap_a: assert property ($fell(core_reset) |-> $past(reset_pin_n, 18) && !$past(supply_below_por, 18))
    else $error("core released too soon");
endmodule

bind reset_source_and_startup_delay reset_ctrl_checker chk (.core_clk, .rst, .supply_below_por, .reset_pin_n,
  .watchdog_enable, .watchdog_expired, .supply_monitor_enable_fuse, .wake_from_powerdown, .cause_write,
  .cause_wdata, .reset_cause_flags, .core_reset, .fetch_addr);

/* verif/supply_pin_model.sv */
// Partner model: reset pin driver, supply monitors and free-running watchdog oscillator.
module supply_pin_model
(
  // Commands from the bench
  input wire logic por_cmd,
  input wire logic pin_cmd,
  input wire logic drop_cmd,
  // Lines into the block
  output logic supply_below_por,
  output logic reset_pin_n,
  output logic supply_drop_detector,
  output logic watchdog_osc
);
  timeunit 1ns;
  timeprecision 1ns;
  // The pin has a pull-up, so a released driver reads high.
  assign reset_pin_n = !pin_cmd;
  assign supply_below_por = por_cmd;
  assign supply_drop_detector = drop_cmd;
  // The oscillator is unrelated to core_clk, so counts are only known to one period.
  initial
  begin
    watchdog_osc = 1'b0;
    #7;
    forever #150 watchdog_osc = ~watchdog_osc;
  end
endmodule

/* verif/tb.sv */
// Testbench: drives the reset controller through its sources and checks delays and cause flags.
`define CHK(nm, exp, got) \
  begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module tb
  import reset_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LONG_N = 16;
  localparam int MED_N = 8;
  typedef struct {logic [1:0] sel; logic bod_n; int osc;} row_t;
  row_t rows [5] = '{'{2'h0, 1'b1, LONG_N}, '{2'h1, 1'b1, LONG_N}, '{2'h2, 1'b1, MED_N},
    '{2'h3, 1'b1, OSC_SHORT_NOBOD}, '{2'h3, 1'b0, OSC_SHORT_BOD}};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic por_cmd = 1'b1, pin_cmd = 1'b0, drop_cmd = 1'b0;
  logic supply_below_por, reset_pin_n, supply_drop_detector, watchdog_osc;
  logic watchdog_enable = 1'b0, watchdog_expired = 1'b0, wake_from_powerdown = 1'b0, cause_write = 1'b0;
  logic [7:0] cause_wdata = 8'h00;
  fuse_set_t fz = '{2'h0, 1'b1, 1'b0};
  logic [7:0] reset_cause_flags;
  logic core_reset, io_reset, brownout_monitor_active;
  logic [8:0] fetch_addr;
  logic [1:0] effective_delay_select;
  int failures = 0;
  int comparisons = 0;
  int n;

  supply_pin_model partner (.por_cmd, .pin_cmd, .drop_cmd, .supply_below_por, .reset_pin_n,
    .supply_drop_detector, .watchdog_osc);
  reset_source_and_startup_delay #(.LONG_OSC_CYCLES(LONG_N), .MEDIUM_OSC_CYCLES(MED_N)) dut (.core_clk, .rst,
    .supply_below_por, .supply_drop_detector, .reset_pin_n, .watchdog_osc, .watchdog_enable, .watchdog_expired,
    .startup_delay_select_fuse(fz.startup_delay_select_fuse), .supply_monitor_enable_fuse(fz.supply_monitor_enable_fuse),
    .supply_trigger_level_fuse(fz.supply_trigger_level_fuse), .wake_from_powerdown, .cause_write, .cause_wdata,
    .reset_cause_flags, .core_reset, .io_reset, .fetch_addr, .brownout_monitor_active, .effective_delay_select);

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Counts cycles until the core is let go; the bound keeps a stuck reset from hanging the run.
  task automatic wait_run(output int c);
    c = 0;
    while (core_reset !== 1'b0 && c < 4000)
    begin
      @(negedge core_clk);
      c++;
    end
    `CHK("core release", 1'b0, core_reset)
  endtask
  task automatic clear_flags();
    @(posedge core_clk);
    cause_write <= 1'b1;
    @(posedge core_clk);
    cause_write <= 1'b0;
    tick(2);
  endtask

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    #400000;
    failures++;
    print_verdict();
  end
  initial
  begin
    tick(11);
    @(negedge core_clk);
    `CHK("flags in reset", 8'h00, reset_cause_flags)
    `CHK("core held", 1'b1, core_reset)
    `CHK("io held", 1'b1, io_reset)
    `CHK("fetch start", RESET_FETCH_ADDR, fetch_addr)
    @(posedge core_clk);
    rst <= 1'b0;
    tick(5);
    por_cmd <= 1'b0;
    wait_run(n);
    `CHK("power-up flag", 8'h01, reset_cause_flags)
    `CHK("io free", 1'b0, io_reset)
    $display("test power-up done");
    foreach (rows[i])
    begin
      clear_flags();
      pin_cmd <= 1'b1;
      fz.startup_delay_select_fuse <= rows[i].sel;
      fz.supply_monitor_enable_fuse <= rows[i].bod_n;
      tick(20);
      pin_cmd <= 1'b0;
      `CHK("select copy", rows[i].sel, effective_delay_select)
      `CHK("pin held", 1'b1, core_reset)
      wait_run(n);
      `CHK("delay floor", 1'b1, n >= (rows[i].osc - 1) * 7 + 18)
      `CHK("delay ceiling", 1'b1, n <= rows[i].osc * 8 + 30)
      `CHK("pin flag", 8'h02, reset_cause_flags)
      `CHK("monitor decode", ~rows[i].bod_n, brownout_monitor_active)
      $display("test row %0d done", i);
    end
    clear_flags();
    pin_cmd <= 1'b1;
    tick(8);
    pin_cmd <= 1'b0;
    tick(30);
    `CHK("short pulse", 8'h00, reset_cause_flags)
    watchdog_expired <= 1'b1;
    tick(3);
    `CHK("watchdog off", 1'b0, core_reset)
    watchdog_enable <= 1'b1;
    tick(1);
    watchdog_enable <= 1'b0;
    watchdog_expired <= 1'b0;
    tick(3);
    `CHK("watchdog pulse", 1'b1, core_reset)
    wait_run(n);
    `CHK("watchdog flag", 8'h08, reset_cause_flags)
    $display("test pin pulse and watchdog done");
    clear_flags();
    fz.supply_monitor_enable_fuse <= 1'b1;
    drop_cmd <= 1'b1;
    tick(100);
    `CHK("monitor off", 8'h00, reset_cause_flags)
    fz.supply_monitor_enable_fuse <= 1'b0;
    tick(60);
    `CHK("fast level wait", 1'b0, core_reset)
    fz.supply_trigger_level_fuse <= 1'b1;
    tick(100);
    `CHK("slow level wait", 1'b0, core_reset)
    tick(40);
    `CHK("brown-out hold", 1'b1, core_reset)
    fz.supply_trigger_level_fuse <= 1'b0;
    drop_cmd <= 1'b0;
    wait_run(n);
    `CHK("brown-out flag", 8'h04, reset_cause_flags)
    $display("test brown-out done");
    por_cmd <= 1'b1;
    tick(6);
    `CHK("low supply", 1'b1, core_reset)
    por_cmd <= 1'b0;
    tick(150);
    pin_cmd <= 1'b1;
    tick(20);
    pin_cmd <= 1'b0;
    wait_run(n);
    `CHK("restart floor", 1'b1, n >= 31 * 7 + 18)
    `CHK("power-up clears", 8'h03, reset_cause_flags)
    $display("test restart done");
    wake_from_powerdown <= 1'b1;
    tick(5);
    wake_from_powerdown <= 1'b0;
    tick(4);
    @(negedge core_clk);
    `CHK("wake core", 1'b1, core_reset)
    `CHK("wake io", 1'b0, io_reset)
    wait_run(n);
    `CHK("wake short", 1'b1, n <= 25)
    $display("test wake done");
    print_verdict();
  end
endmodule
